// ---- rtl/ivm_consts.svh ----
// Address map, vector and register constants for the interrupt vector block
`ifndef IVM_CONSTS_SVH
`define IVM_CONSTS_SVH

// -----------------------------------------------------------------
// Address map
// -----------------------------------------------------------------
`define IVM_REG_BASE 16'h0000
`define IVM_REG_LAST 16'h00BF
`define IVM_RAM_BASE 16'h00C0
`define IVM_RAM_LAST 16'h02BF
`define IVM_STACK_BASE 16'h0100
`define IVM_STACK_TOP 16'h013F
`define IVM_ROM_BASE 16'hC000
`define IVM_EXT_CTRL_ADDR 16'h0008
`define IVM_EXT_CTRL_RESET 8'h00

// -----------------------------------------------------------------
// Vector pair low addresses
// -----------------------------------------------------------------
`define IVM_VEC_USB 16'hFFF0
`define IVM_VEC_SERIAL 16'hFFF2
`define IVM_VEC_TWI 16'hFFF4
`define IVM_VEC_TIMER 16'hFFF6
`define IVM_VEC_EXT 16'hFFF8
`define IVM_VEC_USB_END_SUSP 16'hFFFA
`define IVM_VEC_SOFT 16'hFFFC
`define IVM_VEC_RESET 16'hFFFE

`endif

// ---- rtl/ivm_irq_vector.sv ----
// Interrupt vector selection, wake-up and address decode for the core
`timescale 1ns/1ps
`include "ivm_consts.svh"

module ivm_irq_vector #(
    parameter bit HAS_SERIAL = 1'b1,
    parameter bit HAS_TWI = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Interrupt sources
    input wire logic [7:0] ext_irq_pins,
    input wire logic usb_irq,
    input wire logic usb_end_susp_irq,
    input wire logic serial_irq,
    input wire logic twi_irq,
    input wire logic timer_irq,
    input wire logic soft_irq,
    // CPU core side
    input wire logic mask_clear,
    input wire logic mask_set,
    input wire logic halt_enter,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic ctrl_sel,
    output ivm_pkg::ivm_region_t region,
    output logic stack_ok,
    output logic vec_valid,
    output logic [15:0] vec_addr,
    output logic vec_rd,
    output logic [7:0] vec_data_dummy,
    output logic mask_bit,
    output logic halted,
    output logic [7:0] ext_irq_pending,
    // Pin configuration
    output logic main_clock_out_pin_en
);
    import ivm_pkg::*;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic [7:0] ext_meta;
    logic [7:0] ext_sync;
    logic [7:0] ext_prev;
    logic [5:0] int_meta;
    logic [5:0] int_sync;
    logic [5:0] int_prev;
    logic [5:0] int_raw;

    assign int_raw = {soft_irq, usb_end_susp_irq, timer_irq,
                      twi_irq & HAS_TWI, serial_irq & HAS_SERIAL, usb_irq};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 8'h00;
            ext_sync <= 8'h00;
            ext_prev <= 8'h00;
            int_meta <= 6'h00;
            int_sync <= 6'h00;
            int_prev <= 6'h00;
        end else begin
            ext_meta <= ext_irq_pins;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            int_meta <= int_raw;
            int_sync <= int_meta;
            int_prev <= int_sync;
        end
    end

    // -----------------------------------------------------------------
    // Control register: per-line enable of the external lines
    // -----------------------------------------------------------------
    logic [7:0] external_irq_control;
    logic ctrl_hit;

    assign ctrl_hit = (cpu_addr == `IVM_EXT_CTRL_ADDR);
    assign ctrl_sel = ctrl_hit;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            external_irq_control <= `IVM_EXT_CTRL_RESET;
        end else if (cpu_wr && ctrl_hit) begin
            external_irq_control <= cpu_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd && ctrl_hit) begin
            cpu_rdata <= external_irq_control;
        end else if (cpu_rd) begin
            cpu_rdata <= ext_irq_pending; // Pending lines mirror elsewhere
        end
    end

    // -----------------------------------------------------------------
    // Pending latches
    // -----------------------------------------------------------------
    // Index: 0 usb, 1 serial, 2 twi, 3 timer, 4 ext, 5 end susp, 6 soft
    logic [6:0] pend;
    logic [6:0] rise;
    logic [6:0] take;
    logic [7:0] ext_rise;
    ivm_state_t state;

    assign ext_rise = ext_sync & ~ext_prev & external_irq_control;
    // Edges only: a level still high must not re-arm a request already taken
    assign rise = {int_sync[5:4] & ~int_prev[5:4], |ext_rise,
                   int_sync[3:0] & ~int_prev[3:0]};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_pending <= 8'h00;
        end else begin
            // Set wins over clear
            ext_irq_pending <= (ext_irq_pending & ~{8{take[4]}}) | ext_rise;
        end
    end

    generate
        for (genvar i = 0; i < 7; i++) begin : g_pend
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pend[i] <= 1'b0;
                end else begin
                    pend[i] <= (pend[i] & ~take[i]) | rise[i];
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Selection: fixed priority, highest vector address wins
    // -----------------------------------------------------------------
    logic [6:0] eligible;
    logic [15:0] next_vec;
    logic reset_fetch;

    assign eligible = {pend[6], pend[5:0] & {6{~mask_bit}}};

    always_comb begin
        take = 7'h00;
        next_vec = `IVM_VEC_RESET;
        // Nothing is taken while halted or ahead of the reset fetch
        if (state == IVM_IDLE && !reset_fetch && !halted) begin
            if (eligible[6]) begin
                take[6] = 1'b1;
                next_vec = `IVM_VEC_SOFT;
            end else if (eligible[5]) begin
                take[5] = 1'b1;
                next_vec = `IVM_VEC_USB_END_SUSP;
            end else if (eligible[4]) begin
                take[4] = 1'b1;
                next_vec = `IVM_VEC_EXT;
            end else if (eligible[3]) begin
                take[3] = 1'b1;
                next_vec = `IVM_VEC_TIMER;
            end else if (eligible[2]) begin
                take[2] = 1'b1;
                next_vec = `IVM_VEC_TWI;
            end else if (eligible[1]) begin
                take[1] = 1'b1;
                next_vec = `IVM_VEC_SERIAL;
            end else if (eligible[0]) begin
                take[0] = 1'b1;
                next_vec = `IVM_VEC_USB;
            end
        end
    end

    // -----------------------------------------------------------------
    // Vector fetch sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= IVM_IDLE;
            vec_addr <= `IVM_VEC_RESET;
            reset_fetch <= 1'b1;
        end else begin
            case (state)
                IVM_IDLE: begin
                    if (reset_fetch) begin
                        vec_addr <= `IVM_VEC_RESET;
                        reset_fetch <= 1'b0;
                        state <= IVM_FETCH_HI;
                    end else if (|take) begin
                        vec_addr <= next_vec;
                        state <= IVM_FETCH_HI;
                    end
                end
                IVM_FETCH_HI: begin
                    vec_addr <= vec_addr + 16'h0001;
                    state <= IVM_FETCH_LO;
                end
                IVM_FETCH_LO: begin
                    state <= IVM_IDLE;
                end
                default: begin
                    state <= IVM_IDLE;
                end
            endcase
        end
    end

    assign vec_rd = (state != IVM_IDLE);
    assign vec_valid = (state == IVM_FETCH_LO);
    assign vec_data_dummy = 8'h00;

    // -----------------------------------------------------------------
    // Global mask bit: set at reset and on every entry
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_bit <= 1'b1;
        end else if ((state == IVM_IDLE && (|take || reset_fetch))
                     || mask_set) begin
            mask_bit <= 1'b1;
        end else if (mask_clear) begin
            mask_bit <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Halt and wake-up; the software interrupt cannot wake
    // -----------------------------------------------------------------
    logic wake;

    assign wake = |ext_rise | (int_sync[4] & ~int_prev[4]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            halted <= 1'b0;
        end else if (wake) begin
            halted <= 1'b0;
        end else if (halt_enter) begin
            halted <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    always_comb begin
        if (cpu_addr <= `IVM_REG_LAST) begin
            region = IVM_REGION_PERIPH;
        end else if (cpu_addr >= `IVM_STACK_BASE &&
                     cpu_addr <= `IVM_STACK_TOP) begin
            region = IVM_REGION_STACK;
        end else if (cpu_addr <= `IVM_RAM_LAST) begin
            region = IVM_REGION_RAM;
        end else if (cpu_addr >= `IVM_VEC_USB) begin
            region = IVM_REGION_VECTOR;
        end else if (cpu_addr >= `IVM_ROM_BASE) begin
            region = IVM_REGION_ROM;
        end else begin
            region = IVM_REGION_RESERVED;
        end
    end

    assign stack_ok = (region == IVM_REGION_STACK);

    // Pin keeps its plain port role while reset holds
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_clock_out_pin_en <= 1'b0;
        end else begin
            main_clock_out_pin_en <= 1'b1;
        end
    end

endmodule : ivm_irq_vector

// ---- rtl/ivm_pkg.sv ----
// Types for the interrupt vector block
package ivm_pkg;

    // Address region kinds
    typedef enum logic [2:0] {
        IVM_REGION_PERIPH,
        IVM_REGION_RAM,
        IVM_REGION_STACK,
        IVM_REGION_ROM,
        IVM_REGION_VECTOR,
        IVM_REGION_RESERVED
    } ivm_region_t;

    // Fetch sequencer states
    typedef enum logic [1:0] {
        IVM_IDLE,
        IVM_FETCH_HI,
        IVM_FETCH_LO
    } ivm_state_t;

endpackage : ivm_pkg

// ---- tb/ivm_irq_vector_checker.sv ----
// Port-level assertions for the interrupt vector block
`timescale 1ns/1ps
module ivm_irq_vector_checker
    import ivm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire logic [15:0] cpu_addr,
    input wire logic ctrl_sel,
    input wire ivm_region_t region,
    input wire logic stack_ok,
    input wire logic vec_valid,
    input wire logic [15:0] vec_addr,
    input wire logic vec_rd,
    input wire logic mask_bit,
    input wire logic halted,
    input wire logic main_clock_out_pin_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------
    // Fetch steps
    // ------------------------------------------------
    sequence fetch_pair;
        vec_rd ##1 (vec_rd && vec_valid) ##1 !vec_rd;
    endsequence
    // Pin stays parked until the first edge, which also starts the fetch
    sequence reset_entry;
        !main_clock_out_pin_en ##1
            (vec_rd && vec_addr == 16'hFFFE && main_clock_out_pin_en);
    endsequence
    a_fetch_two_cycles: assert property (
        $rose(vec_rd) |-> fetch_pair) else $error("fetch length wrong");
    a_even_first: assert property (
        $rose(vec_rd) |-> vec_addr[15:4] == 12'hFFF && !vec_addr[0])
        else $error("first fetch byte not an even vector");
    a_mask_on_entry: assert property (
        $rose(vec_rd) |-> mask_bit) else $error("mask not set on entry");
    a_odd_second: assert property (
        vec_valid |-> vec_rd && vec_addr == $past(vec_addr) + 16'h0001)
        else $error("second fetch byte not the odd one");
    a_addr_hold: assert property (
        !vec_rd |-> $stable(vec_addr)) else $error("vector moved while idle");
    a_stack_window: assert property (
        stack_ok == (cpu_addr >= 16'h0100 && cpu_addr <= 16'h013F))
        else $error("stack window decode wrong");
    a_periph_region: assert property (
        cpu_addr <= 16'h00BF |-> region == IVM_REGION_PERIPH)
        else $error("register space decode wrong");
    a_ctrl_decode: assert property (
        ctrl_sel == (cpu_addr == 16'h0008)) else $error("control select wrong");
    a_reset_fetch: assert property (
        $rose(rst_n) |-> reset_entry) else $error("reset fetch wrong");
    a_halt_no_fetch: assert property (
        halted && !vec_rd |=> !vec_rd) else $error("fetch while halted");
endmodule : ivm_irq_vector_checker

bind ivm_irq_vector ivm_irq_vector_checker chk_u (.clock, .rst_n,
    .cpu_addr, .ctrl_sel, .region, .stack_ok, .vec_valid, .vec_addr,
    .vec_rd, .mask_bit, .halted, .main_clock_out_pin_en);

// ---- tb/ivm_src_model.sv ----
// Interrupt source model: one-cycle requests become held levels
`timescale 1ns/1ps
module ivm_src_model (
    // Clock
    input wire logic clock,
    // Requests from the bench
    input wire logic [6:0] fire,
    input wire logic [7:0] ext_sel,
    // Source levels
    output logic [6:0] lines,
    output logic [7:0] ext_pins
);
    logic [2:0] age [7];
    initial for (int i = 0; i < 7; i++) age[i] = 3'h0;
    // Held six cycles so the synchroniser surely sees the edge
    always @(posedge clock) begin
        for (int i = 0; i < 7; i++) begin
            if (fire[i]) age[i] <= 3'h6;
            else if (age[i] != 3'h0) age[i] <= age[i] - 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 7; i++) lines[i] = (age[i] != 3'h0);
        ext_pins = lines[4] ? ext_sel : 8'h00;
    end
endmodule : ivm_src_model

// ---- tb/testbench.sv ----
// Self-checking bench for the interrupt vector block
`timescale 1ns/1ps
module testbench;
    import ivm_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] fire = 7'h00;
    logic [7:0] ext_sel = 8'h01;
    logic mask_clear = 1'b0;
    logic mask_set = 1'b0;
    logic [7:0] vec_data_dummy;
    logic [7:0] ext_irq_pending;
    logic halt_enter = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [6:0] lines;
    logic [7:0] ext_pins, cpu_rdata;
    logic ctrl_sel, stack_ok, vec_valid, vec_rd, mask_bit, halted;
    logic main_clock_out_pin_en;
    logic [15:0] vec_addr;
    ivm_region_t region;
    logic [15:0] exp_q [$];
    int n_fail = 0;
    int samples_checked = 0;
    int n_fetch = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    ivm_src_model src_u (.clock, .fire, .ext_sel, .lines, .ext_pins);
    ivm_irq_vector dut_u (.clock, .rst_n, .ext_irq_pins(ext_pins),
        .usb_irq(lines[0]), .serial_irq(lines[1]), .twi_irq(lines[2]),
        .timer_irq(lines[3]), .usb_end_susp_irq(lines[5]),
        .soft_irq(lines[6]), .mask_clear, .mask_set, .halt_enter,
        .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .ctrl_sel,
        .region, .stack_ok, .vec_valid, .vec_addr, .vec_rd,
        .vec_data_dummy, .mask_bit, .halted, .ext_irq_pending,
        .main_clock_out_pin_en);
    // ------------------------------------------------
    // Checking and closing
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    // Each second fetch byte retires the oldest expected vector
    always @(negedge clock) begin
        if (rst_n && vec_valid === 1'b1) begin
            n_fetch++;
            if (exp_q.size() == 0) check("vec_addr", vec_addr, 16'h0000);
            else check("vec_addr", vec_addr, exp_q.pop_front() + 16'h1);
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic pulse(input logic [6:0] src);
        @(negedge clock) fire = src;
        @(negedge clock) fire = 7'h00;
    endtask : pulse
    task automatic clr_mask();
        @(negedge clock) mask_clear = 1'b1;
        @(negedge clock) mask_clear = 1'b0;
    endtask : clr_mask
    task automatic expect_fetch(input logic [15:0] v);
        exp_q.push_back(v);
        for (int k = 0; k < 40 && exp_q.size() != 0; k++) @(negedge clock);
        check("pending", 16'(exp_q.size()), 16'h0000);
        repeat (2) @(negedge clock);
    endtask : expect_fetch
    task automatic quiet(input int n);
        int m;
        m = n_fetch;
        repeat (n) begin
            @(negedge clock);
            cpu_addr = 16'($urandom); // address moves with no strobe
        end
        check("fetches", 16'(n_fetch - m), 16'h0000);
    endtask : quiet
    task automatic reg_rw(input logic [7:0] d);
        @(negedge clock);
        cpu_addr = 16'h0008;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clock);
        cpu_wr = 1'b0;
        cpu_rd = 1'b1;
        @(negedge clock);
        cpu_rd = 1'b0;
        check("control", {8'h00, cpu_rdata}, {8'h00, d});
    endtask : reg_rw
    initial begin
        void'($urandom(32'h6A0E));
        repeat (16) @(negedge clock);
        check("pin_en", {15'h0, main_clock_out_pin_en}, 16'h0000);
        rst_n = 1'b1;
        expect_fetch(16'hFFFE);
        check("pin_en", {15'h0, main_clock_out_pin_en}, 16'h0001);
        reg_rw(8'($urandom));
        reg_rw(8'hFF);
        for (int i = 0; i < 7; i++) begin
            ext_sel = 8'($urandom) | 8'h01;
            clr_mask();
            pulse(7'h01 << i);
            expect_fetch(16'hFFF0 + 16'(2 * i));
            check("mask_bit", {15'h0, mask_bit}, 16'h0001);
        end
        pulse(7'h08);
        quiet(20);
        clr_mask();
        expect_fetch(16'hFFF6);
        pulse(7'h40);
        expect_fetch(16'hFFFC);
        clr_mask();
        pulse(7'h18);
        expect_fetch(16'hFFF8);
        clr_mask();
        expect_fetch(16'hFFF6);
        clr_mask();
        @(negedge clock) halt_enter = 1'b1;
        @(negedge clock) halt_enter = 1'b0;
        pulse(7'h08);
        quiet(20);
        check("halted", {15'h0, halted}, 16'h0001);
        pulse(7'h10);
        expect_fetch(16'hFFF8);
        check("halted", {15'h0, halted}, 16'h0000);
        clr_mask();
        expect_fetch(16'hFFF6);
        clr_mask();
        @(negedge clock) mask_set = 1'b1;
        @(negedge clock) mask_set = 1'b0;
        pulse(7'h10);
        quiet(20);
        check("mask_bit", {15'h0, mask_bit}, 16'h0001);
        check("ext_pending", {8'h00, ext_irq_pending}, {8'h00, ext_sel});
        clr_mask();
        expect_fetch(16'hFFF8);
        check("ext_pending", {8'h00, ext_irq_pending}, 16'h0000);
        check("dummy", {8'h00, vec_data_dummy}, 16'h0000);
        conclude();
    end
endmodule : testbench
